// >>> hw/gray_dac_ctrl.v
/*
 serial control of the dual converter grayscale reference: word
 receive, double-buffered code registers, sleep/shutdown priority,
 output buffer enables and common-electrode routing.
 assumes the serial pins and control pins are asynchronous to clk and
 that the shift clock stays at or below 12.5 MHz with clk at 100 MHz.
*/
`timescale 1ns/1ns
`include "gray_dac_consts.vh"

module gray_dac_ctrl (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // serial port
  input wire shift_clk,
  input wire serial_data,
  input wire load_strobe_n,
  // power control pins
  input wire shutdown_n,
  input wire mid_sleep_a,
  input wire mid_sleep_b,
  // electrode and top output control pins
  input wire logic_enable,
  input wire level_pick,
  input wire top_output_route,
  // converter codes
  output reg [`DATA_BITS-1:0] upper_code,
  output reg [`DATA_BITS-1:0] lower_code,
  // power state and buffer enables
  output reg asleep,
  output reg full_shutdown,
  output reg [4:0] level_buf_en,
  output reg input_stage_en,
  // electrode and top output routing
  output reg [1:0] electrode_sel,
  output reg top_to_electrode,
  output reg top_buffer_amp_en
);
  wire sck_s;
  wire din_s;
  wire ld_n_s;
  wire sd_n_s;
  wire slp_a_s;
  wire slp_b_s;
  wire en_s;
  wire pick_s;
  wire route_s;

  pin_sync #(
    .RST_VAL(1'b0)
  ) u_sck (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(shift_clk),
    .level(sck_s)
  );

  pin_sync #(
    .RST_VAL(1'b0)
  ) u_din (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(serial_data),
    .level(din_s)
  );

  pin_sync #(
    .RST_VAL(1'b1)
  ) u_ld (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(load_strobe_n),
    .level(ld_n_s)
  );

  pin_sync #(
    .RST_VAL(1'b1)
  ) u_sd (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(shutdown_n),
    .level(sd_n_s)
  );

  pin_sync #(
    .RST_VAL(1'b0)
  ) u_slpa (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(mid_sleep_a),
    .level(slp_a_s)
  );

  pin_sync #(
    .RST_VAL(1'b0)
  ) u_slpb (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(mid_sleep_b),
    .level(slp_b_s)
  );

  pin_sync #(
    .RST_VAL(1'b0)
  ) u_en (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(logic_enable),
    .level(en_s)
  );

  pin_sync #(
    .RST_VAL(1'b0)
  ) u_pick (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(level_pick),
    .level(pick_s)
  );

  pin_sync #(
    .RST_VAL(1'b0)
  ) u_route (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(top_output_route),
    .level(route_s)
  );

  // edge detection on synchronised levels
  reg sck_d_r;
  reg ld_n_d_r;
  wire sck_rise = sck_s & ~sck_d_r;
  wire ld_fall = ld_n_d_r & ~ld_n_s;
  wire ld_rise = ~ld_n_d_r & ld_n_s;

  reg [`WORD_BITS-1:0] shift_r;
  reg [`CNT_BITS-1:0] count_r;
  reg armed_r;
  reg [`DATA_BITS-1:0] in_a_r;
  reg [`DATA_BITS-1:0] in_b_r;
  reg [`DATA_BITS-1:0] dac_a_r;
  reg [`DATA_BITS-1:0] dac_b_r;
  reg sleep_r;

  wire word_full = (count_r == `WORD_BITS);
  wire [`CODE_BITS-1:0] code = shift_r[`CODE_MSB:`CODE_LSB];
  wire [`DATA_BITS-1:0] data = shift_r[`DATA_MSB:`DATA_LSB];
  wire commit = ld_rise & word_full;

  always @(posedge clk) begin
    if (sys_rst) begin
      sck_d_r <= 1'b0;
      ld_n_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      ld_n_d_r <= ld_n_s;
    end
  end

  // serial receive
  always @(posedge clk) begin
    if (sys_rst) begin
      shift_r <= {`WORD_BITS{1'b0}};
      count_r <= {`CNT_BITS{1'b0}};
      armed_r <= 1'b0;
    end else if (ld_fall) begin
      shift_r <= {`WORD_BITS{1'b0}};
      count_r <= {`CNT_BITS{1'b0}};
      armed_r <= 1'b1;
    end else if (ld_rise) begin
      shift_r <= {`WORD_BITS{1'b0}};
      count_r <= {`CNT_BITS{1'b0}};
      armed_r <= 1'b0;
    end else if (armed_r && !ld_n_s && sck_rise) begin
      shift_r <= {shift_r[`WORD_BITS-2:0], din_s};
      count_r <= count_r + 1'b1;
      if (count_r == `WORD_BITS - 1) begin
        armed_r <= 1'b0;
      end
    end
  end

  // command decode; only complete words commit
  always @(posedge clk) begin
    if (sys_rst) begin
      in_a_r <= `PRESET_UPPER;
      in_b_r <= `PRESET_LOWER;
      dac_a_r <= `PRESET_UPPER;
      dac_b_r <= `PRESET_LOWER;
      sleep_r <= 1'b0;
    end else if (commit) begin
      case (code)
        `CC_NOP: begin
        end
        `CC_LOAD_A: begin
          in_a_r <= data;
        end
        `CC_LOAD_B: begin
          in_b_r <= data;
        end
        `CC_UPDATE: begin
          dac_a_r <= in_a_r;
          dac_b_r <= in_b_r;
          sleep_r <= 1'b0;
        end
        `CC_LOAD_A_UPD: begin
          in_a_r <= data;
          dac_a_r <= data;
          dac_b_r <= in_b_r;
          sleep_r <= 1'b0;
        end
        `CC_LOAD_B_UPD: begin
          in_b_r <= data;
          dac_b_r <= data;
          dac_a_r <= in_a_r;
          sleep_r <= 1'b0;
        end
        `CC_WAKE: begin
          sleep_r <= 1'b0;
        end
        `CC_SLEEP: begin
          sleep_r <= 1'b1;
        end
        `CC_LOAD_BOTH_UPD: begin
          in_a_r <= data;
          in_b_r <= data;
          dac_a_r <= data;
          dac_b_r <= data;
          sleep_r <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // shutdown priority and output stage
  wire [1:0] esel;
  wire t2e;
  wire amp_en;

  output_select u_sel (
    .logic_enable(en_s),
    .level_pick(pick_s),
    .top_output_route(route_s),
    .electrode_sel(esel),
    .top_to_electrode(t2e),
    .top_buffer_amp_en(amp_en)
  );

  wire full_nxt = ~sd_n_s | sleep_r;
  wire mid_off_nxt = slp_a_s & slp_b_s;

  always @(posedge clk) begin
    if (sys_rst) begin
      upper_code <= `PRESET_UPPER;
      lower_code <= `PRESET_LOWER;
      asleep <= 1'b0;
      full_shutdown <= 1'b0;
      level_buf_en <= `BUF_ALL_ON;
      input_stage_en <= 1'b0;
      electrode_sel <= `SEL_MID;
      top_to_electrode <= 1'b1;
      top_buffer_amp_en <= 1'b0;
    end else begin
      upper_code <= dac_a_r;
      lower_code <= dac_b_r;
      asleep <= sleep_r;
      full_shutdown <= full_nxt;
      if (full_nxt) begin
        level_buf_en <= `BUF_ALL_OFF;
      end else if (mid_off_nxt) begin
        level_buf_en <= `BUF_MID_OFF;
      end else begin
        level_buf_en <= `BUF_ALL_ON;
      end
      input_stage_en <= armed_r;
      electrode_sel <= esel;
      top_to_electrode <= t2e;
      top_buffer_amp_en <= amp_en & ~full_nxt;
    end
  end
endmodule

// >>> include/gray_dac_consts.vh
/*
 constants for the grayscale reference control block: word layout,
 control codes, preset converter codes and select encodings.
 assumes inclusion by bare name from the design files.
*/
`ifndef GRAY_DAC_CONSTS_VH
`define GRAY_DAC_CONSTS_VH

`define WORD_BITS 16
`define CODE_BITS 4
`define DATA_BITS 10
`define CNT_BITS 5
`define CODE_MSB 15
`define CODE_LSB 12
`define DATA_MSB 11
`define DATA_LSB 2

`define CC_NOP 4'h0
`define CC_LOAD_A 4'h1
`define CC_LOAD_B 4'h2
`define CC_UPDATE 4'h8
`define CC_LOAD_A_UPD 4'h9
`define CC_LOAD_B_UPD 4'ha
`define CC_WAKE 4'hd
`define CC_SLEEP 4'he
`define CC_LOAD_BOTH_UPD 4'hf

`define PRESET_UPPER 10'h3af
`define PRESET_LOWER 10'h028

`define SEL_MID 2'h0
`define SEL_LOW 2'h1
`define SEL_HIGH 2'h2

`define BUF_ALL_ON 5'h1f
`define BUF_MID_OFF 5'h11
`define BUF_ALL_OFF 5'h00

`endif

// >>> hw/pin_sync.v
/*
 two flip-flop synchroniser for one asynchronous pin.
 assumes clk is the block clock; reset value is a parameter.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter RST_VAL = 1'b0
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // pin and synchronised level
  input wire pin,
  output wire level
);
  reg meta_r;
  reg sync_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
    end
  end

  assign level = sync_r;
endmodule

// >>> hw/output_select.v
/*
 combinational common-electrode and top-output routing selection.
 assumes all inputs already synchronised to the block clock.
*/
`timescale 1ns/1ns
`include "gray_dac_consts.vh"
module output_select (
  // selection inputs
  input wire logic_enable,
  input wire level_pick,
  input wire top_output_route,
  // selections
  output reg [1:0] electrode_sel,
  output wire top_to_electrode,
  output wire top_buffer_amp_en
);
  always @* begin
    if (!logic_enable) begin
      electrode_sel = `SEL_MID;
    end else if (level_pick) begin
      electrode_sel = `SEL_HIGH;
    end else begin
      electrode_sel = `SEL_LOW;
    end
  end

  assign top_to_electrode = ~top_output_route;
  assign top_buffer_amp_en = top_output_route;
endmodule

// >>> test/gray_dac_ctrl_assertions.sv
/* checker on the control block ports.
 assumes the bench drives pins just after clk rises. */
`timescale 1ns/1ns
module gray_dac_ctrl_chk (
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // pins
  input logic load_strobe_n,
  input logic shutdown_n,
  input logic mid_sleep_a,
  input logic mid_sleep_b,
  input logic logic_enable,
  input logic level_pick,
  input logic top_output_route,
  // state
  input logic [9:0] upper_code,
  input logic [9:0] lower_code,
  input logic asleep,
  input logic full_shutdown,
  input logic [4:0] level_buf_en,
  input logic input_stage_en,
  input logic [1:0] electrode_sel,
  input logic top_to_electrode,
  input logic top_buffer_amp_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_pin_shut: assert property (
    !shutdown_n [*4] |-> full_shutdown) else $error("pin shutdown missed");
  a_shut_bufs: assert property (
    full_shutdown |-> level_buf_en == 5'h00 && !top_buffer_amp_en)
    else $error("buffer on in shutdown");
  a_sleep_full: assert property (
    asleep [*3] |-> full_shutdown) else $error("sleep not shut down");
  a_mid_three: assert property (
    (!full_shutdown && mid_sleep_a && mid_sleep_b) [*4]
    |-> level_buf_en == 5'h11) else $error("mid buffers on");
  a_elec_mid: assert property (
    !logic_enable [*4] |-> electrode_sel == 2'h0) else $error("not mid");
  a_elec_pick: assert property (
    (logic_enable && $stable(level_pick)) [*4]
    |-> electrode_sel == {level_pick, !level_pick}) else $error("bad pick");
  a_top_tied: assert property (
    !top_output_route [*4] |-> top_to_electrode && !top_buffer_amp_en)
    else $error("top not tied");
  a_stage_arm: assert property (
    load_strobe_n ##1 !load_strobe_n [*5] |-> input_stage_en)
    else $error("stage not armed");
  a_code_hold: assert property (
    !load_strobe_n [*6] |-> $stable(upper_code) && $stable(lower_code))
    else $error("code moved mid frame");
  c_shut: cover property (full_shutdown);
  c_mid: cover property (level_buf_en == 5'h11);
  c_sleep: cover property ($rose(asleep));
endmodule
bind gray_dac_ctrl gray_dac_ctrl_chk u_gray_dac_ctrl_chk (.*);

// >>> test/host_serial.sv
/* host side of the serial port.
 assumes clk at 100 MHz; shift clock 80 ns, idle low. */
`timescale 1ns/1ns
module host_serial (
  // clock
  input logic clk,
  // serial port
  output logic shift_clk = 1'b0,
  output logic serial_data = 1'b0,
  output logic load_strobe_n = 1'b1
);
  // n below 16 aborts the word early
  task automatic send(input logic [15:0] w, input int n);
    int i;
    @(posedge clk);
    load_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (i = 15; i > 15 - n; i--) begin
      serial_data <= w[i];
      repeat (4) @(posedge clk);
      shift_clk <= 1'b1;
      repeat (4) @(posedge clk);
      shift_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    load_strobe_n <= 1'b1;
    // released line shows no stale level
    serial_data <= ~serial_data;
    repeat (8) @(posedge clk);
  endtask
endmodule

// >>> test/gray_dac_ctrl_tb.sv
/* self-checking bench for the control block.
 assumes host_serial as the serial partner. */
`timescale 1ns/1ns
`include "gray_dac_consts.vh"
module gray_dac_ctrl_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic shutdown_n = 1'b1;
  logic mid_sleep_a = 1'b0;
  logic mid_sleep_b = 1'b0;
  logic logic_enable = 1'b0;
  logic level_pick = 1'b0;
  logic top_output_route = 1'b0;
  logic shift_clk, serial_data, load_strobe_n, asleep, full_shutdown;
  logic input_stage_en, top_to_electrode, top_buffer_amp_en;
  logic [9:0] upper_code, lower_code;
  logic [4:0] level_buf_en;
  logic [1:0] electrode_sel;
  logic [9:0] in_a = `PRESET_UPPER, in_b = `PRESET_LOWER;
  logic [9:0] up = `PRESET_UPPER, lo = `PRESET_LOWER;
  logic slp = 1'b0;
  int fails = 0;
  int tests_run = 0;
  int i;
  always #5 clk = ~clk;
  gray_dac_ctrl u_gray_dac_ctrl (.*);
  host_serial u_host_serial (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic void model(input logic [3:0] c, input logic [9:0] d);
    if (c == `CC_LOAD_A || c == `CC_LOAD_A_UPD || c == `CC_LOAD_BOTH_UPD)
      in_a = d;
    if (c == `CC_LOAD_B || c == `CC_LOAD_B_UPD || c == `CC_LOAD_BOTH_UPD)
      in_b = d;
    if (c == `CC_UPDATE || c[3:2] == 2'h2 && c[1:0] != 2'h3 || c == 4'hf) begin
      up = in_a;
      lo = in_b;
    end
    if (c[3] && c[2:0] != 3'h3 && c[2:0] != 3'h4)
      slp = c == `CC_SLEEP;
  endfunction
  task automatic word(input logic [3:0] c, input logic [9:0] d);
    u_host_serial.send({c, d, 2'h3}, 16);
    #1;
    model(c, d);
    chk(upper_code, up);
    chk(lower_code, lo);
    chk(asleep, slp);
    chk(input_stage_en, 1'b0);
  endtask
  task automatic sweep(input int which);
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (which == 0)
        {shutdown_n, mid_sleep_a, mid_sleep_b} <= i[2:0];
      else
        {logic_enable, level_pick, top_output_route} <= i[2:0];
      repeat (5) @(posedge clk);
      #1;
      if (which == 0) begin
        chk(level_buf_en, !i[2] || slp ? 5'h00 :
          i[1:0] == 2'h3 ? 5'h11 : 5'h1f);
        chk(full_shutdown, !i[2] || slp);
      end else begin
        chk(electrode_sel, !i[2] ? `SEL_MID :
          i[1] ? `SEL_HIGH : `SEL_LOW);
        chk({top_to_electrode, top_buffer_amp_en},
          {!i[0], i[0] && !slp});
      end
    end
  endtask
  initial begin
    void'($urandom(68));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({upper_code, lower_code}, {`PRESET_UPPER, `PRESET_LOWER});
    chk({asleep, full_shutdown, level_buf_en}, 7'h1f);
    $display("test reset done");
    for (int k = 0; k < 40; k++)
      word(k < 16 ? k[3:0] : 4'($urandom), 10'($urandom));
    $display("test codes done");
    u_host_serial.send({4'hf, 12'($urandom)}, 9);
    #1;
    chk({upper_code, lower_code, asleep}, {up, lo, slp});
    $display("test abort done");
    word(`CC_WAKE, 10'h000);
    sweep(0);
    word(`CC_SLEEP, 10'h000);
    sweep(0);
    word(`CC_WAKE, 10'h000);
    $display("test power done");
    sweep(1);
    $display("test routing done");
    test_done;
  end
  initial begin
    #400000;
    fails++;
    test_done;
  end
endmodule
